// >>> sim/lfwf_checker.sv
// Purpose: port-level assertions of the lf wake-up output filter
// Assumes: OSC_DIV clk_sys cycles per oscillator tick
// Notes:   ready is bounded both ways; timeout checks are lower bounds, the bench judges upper ones
`timescale 1ns/100ps
module lfwf_checker #(
    parameter int OSC_DIV     = 625,
    parameter int READY_TICKS = 1600
) (
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire logic                demod_in,
    input wire lfwf_pkg::lfwf_cfg_t  config_word_zero,
    input wire logic                demod_data_out,
    input wire lfwf_pkg::lfwf_stat_t status
);
    import lfwf_pkg::*;

    localparam int RDY_EARLY = (READY_TICKS - 1) * OSC_DIV;
    localparam int RDY_LATE  = (READY_TICKS + 1) * OSC_DIV + 4;
    localparam int INACT_MIN = 511 * OSC_DIV;
    localparam int ALARM_MIN = 1023 * OSC_DIV;
    localparam int LOW_MIN   = 31 * OSC_DIV;

    logic [31:0] up_cnt_r;
    logic [31:0] quiet_cnt_r;
    logic [31:0] alarm_cnt_r;
    logic        din_r;

    // counted at the pin, so always ahead of the synchronised view
    always_ff @(posedge clk_sys) begin
        din_r       <= demod_in;
        up_cnt_r    <= sys_rst ? 32'h0 : up_cnt_r + 32'h1;
        quiet_cnt_r <= (sys_rst || demod_in != din_r) ? 32'h0
                                                      : quiet_cnt_r + 32'h1;
        alarm_cnt_r <= (sys_rst || status.alarm_timeout) ? 32'h0
                                                         : alarm_cnt_r + 32'h1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    chk_reset_clear: assert property (
        $fell(sys_rst) |-> status == 4'h0 && !demod_data_out)
        else $error("outputs not clear after reset");
    chk_ready_early: assert property (
        up_cnt_r < RDY_EARLY |-> !status.ready)
        else $error("ready too early");
    chk_ready_late: assert property (
        up_cnt_r > RDY_LATE |-> status.ready)
        else $error("ready too late");
    chk_unready_quiet: assert property (
        !status.ready |-> !demod_data_out)
        else $error("data while not ready");
    chk_bypass_follow: assert property (
        config_word_zero.min_high_select == 2'h0 &&
        $past(config_word_zero.min_high_select, 3) == 2'h0 &&
        $past(status.ready, 3) |-> demod_data_out == $past(demod_in, 3))
        else $error("bypass output does not follow input");
    chk_closed_gate: assert property (
        config_word_zero.min_high_select != 2'h0 &&
        $past(config_word_zero.min_high_select) != 2'h0 &&
        !status.filter_open && !$past(status.filter_open)
        |-> !demod_data_out)
        else $error("data passed while filter closed");
    // judged three cycles back: a rise still inside the synchroniser
    // at the moment of opening is legal and must not count
    chk_open_low_first: assert property (
        $rose(status.filter_open) |->
        !$past(demod_in, 3) && $past(quiet_cnt_r, 3) >= LOW_MIN)
        else $error("filter opened without minimum low");
    chk_inact_span: assert property (
        status.inactivity_timeout |-> quiet_cnt_r >= INACT_MIN)
        else $error("inactivity timeout too early");
    chk_inact_close: assert property (
        status.inactivity_timeout |=> !status.filter_open)
        else $error("filter still open after inactivity");
    chk_alarm_span: assert property (
        status.alarm_timeout |-> alarm_cnt_r >= ALARM_MIN)
        else $error("alarm timeout too early");
endmodule

bind lfwf_top lfwf_checker #(
    .OSC_DIV     (OSC_DIV),
    .READY_TICKS (READY_TICKS)
) chk (
    .clk_sys          (clk_sys),
    .sys_rst          (sys_rst),
    .demod_in         (demod_in),
    .config_word_zero (config_word_zero),
    .demod_data_out   (demod_data_out),
    .status           (status)
);

// >>> sim/lfwf_top_test.sv
// Purpose: self-checking bench of the lf wake-up output filter
// Assumes: oscillator tick every 4 clk_sys cycles in this run
// Notes:   timings allow for the phase of the tick
`timescale 1ns/100ps
module lfwf_top_test;
    import lfwf_pkg::*;
    localparam int DIV = 4;
    localparam int RDY = 8;
    logic       clk_sys;
    logic       sys_rst;
    logic       demod_in;
    lfwf_cfg_t  cfg;
    logic       demod_data_out;
    lfwf_stat_t status;
    int         n_errors;
    int         n_compared;
    int         mx [16] = '{0, 0, 0, 0, 96, 96, 128, 192,
                            128, 128, 160, 250, 192, 192, 256, 320};

    lfwf_top #(.OSC_DIV(DIV), .READY_TICKS(RDY)) DUT (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .demod_in         (demod_in),
        .config_word_zero (cfg),
        .demod_data_out   (demod_data_out),
        .status           (status)
    );

    lfwf_tx_model #(.OSC_DIV(DIV)) tx (
        .clk_sys  (clk_sys),
        .demod_in (demod_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wait_bit(input int b, output int n);
        n = 0;
        while (status[b] !== 1'b1 && n < 6000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // the sender raises the level at once; the bench waits for ready before expecting anything through
    task automatic t_ready();
        int n;
        tx.hold(1'b1, 0);
        wait_bit(3, n);
        check("ready_time", n inside {[RDY*DIV-4:RDY*DIV+8]}, 1);
        repeat (4) @(negedge clk_sys);
        check("bypass_high", demod_data_out, 1'b1);
        tx.gain_hold();
        check("bypass_steady", demod_data_out, 1'b1);
        tx.hold(1'b0, 4);
        check("bypass_low", demod_data_out, 1'b0);
    endtask

    task automatic t_codes();
        int nh;
        int nl;
        for (int c = 4; c < 16; c++) begin
            nh = 32 << (c / 4 - 1);
            nl = (c % 4 < 2) ? 32 : 32 << (c % 4 - 1);
            cfg = 4'h0;
            tx.hold(1'b0, 4);
            cfg = c[3:0];
            tx.preamble();
            tx.pulse(nh - 2, nl + 3);
            check("open_short_high", status.filter_open, 1'b0);
            tx.pulse(nh + 2, nl - 2);
            check("open_short_low", status.filter_open, 1'b0);
            tx.pulse(mx[c] + 2, nl + 3);
            check("open_over_max", status.filter_open, 1'b0);
            tx.pulse(nh + 2, nl + 3);
            check("open_qualified", status.filter_open, 1'b1);
            tx.hold(1'b1, 4);
            check("data_open", demod_data_out, 1'b1);
        end
    endtask

    task automatic t_timers();
        int n;
        cfg = 4'h0;
        tx.hold(1'b0, 4);
        cfg = 4'h4;
        tx.pulse(34, 35);
        check("open_before_quiet", status.filter_open, 1'b1);
        wait_bit(1, n);
        // 512 ticks from opening; the wait began about 3 ticks after it
        check("inact_time", n inside {[2028:2044]}, 1);
        repeat (2) @(negedge clk_sys);
        check("open_after_inact", status.filter_open, 1'b0);
        tx.hold(1'b1, 0);
        wait_bit(0, n);
        check("alarm_time", n inside {[4088:4104]}, 1);
        tx.hold(1'b0, 4);
    endtask

    initial begin
        n_errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        cfg = 4'h0;
        repeat (2) @(negedge clk_sys);
        check("rst_outputs", {demod_data_out, status}, 5'h00);
        sys_rst = 1'b0;
        t_ready();
        t_codes();
        t_timers();
        report_and_stop();
    end

    // the whole run needs under 3 ms
    initial begin
        #4_000_000;
        n_errors++;
        report_and_stop();
    end
endmodule

// >>> sim/lfwf_tx_model.sv
// Purpose: remote lf sender as seen at the demodulator output
// Assumes: levels change only at falling clk_sys edges
// Notes:   demodulator delays are whole ticks; zero by default
`timescale 1ns/100ps
module lfwf_tx_model #(
    parameter int OSC_DIV = 4,
    parameter int T_RISE  = 0,
    parameter int T_FALL  = 0
) (
    input  wire logic clk_sys,
    output logic      demod_in
);
    initial demod_in = 1'b0;

    // callers ask for 0 ticks only to set a level; other elements are at least 4 ticks, about 125 us
    task automatic hold(input logic lvl, input int ticks);
        demod_in = lvl;
        repeat (ticks * OSC_DIV) @(negedge clk_sys);
    endtask

    // carrier-on and gap corrected by the demodulator delays
    task automatic pulse(input int hi, input int lo);
        hold(1'b1, hi - T_RISE + T_FALL);
        hold(1'b0, lo + T_RISE - T_FALL);
    endtask

    // settling carrier of 128 ticks, then a gap of 8 ticks
    task automatic preamble();
        hold(1'b1, 128);
        hold(1'b0, 8);
    endtask

    // after a gain-hold command the level stays put for 160 ticks, 5 ms
    task automatic gain_hold();
        hold(demod_in, 160);
    endtask
endmodule

// >>> verilog/lfwf_consts.svh
// Purpose: timing counts and table values of the lf wake-up output filter
// Assumes: 20 MHz system clock; 32 kHz nominal filter oscillator
// Notes:   all filter times are counts of oscillator ticks
`ifndef LFWF_CONSTS_SVH
`define LFWF_CONSTS_SVH

`define LFWF_CLK_HZ        32'h01312d00
`define LFWF_OSC_HZ        32'h00007d00
// clk_sys cycles per oscillator tick, rounded down
`define LFWF_OSC_DIV       (`LFWF_CLK_HZ / `LFWF_OSC_HZ)

`define LFWF_TICKS_1MS     9'h020
`define LFWF_TICKS_2MS     9'h040
`define LFWF_TICKS_4MS     9'h080

`define LFWF_MAX_96        9'h060
`define LFWF_MAX_128       9'h080
`define LFWF_MAX_160       9'h0a0
`define LFWF_MAX_192       9'h0c0
`define LFWF_MAX_250       9'h0fa
`define LFWF_MAX_256       9'h100
`define LFWF_MAX_320       9'h140

`define LFWF_INACT_TICKS   32'h00000200
`define LFWF_ALARM_TICKS   32'h00000400

`define LFWF_READY_MS      32'h00000032
// longest time, rounded down
`define LFWF_READY_TICKS   (`LFWF_READY_MS * `LFWF_OSC_HZ / 32'h000003e8)

`define LFWF_SEL_OFF       2'h0
`define LFWF_SEL_1MS       2'h1
`define LFWF_SEL_2MS       2'h2
`define LFWF_SEL_4MS       2'h3

`endif

// >>> verilog/lfwf_pkg.sv
// Purpose: types of the lf wake-up output filter
// Assumes: nothing
// Notes:   the two select codes fill config_word_zero, min_high_select in bits 3:2 and min_low_select in bits 1:0
package lfwf_pkg;

    typedef struct packed {
        logic [1:0] min_high_select;
        logic [1:0] min_low_select;
    } lfwf_cfg_t;

    typedef struct packed {
        logic ready;
        logic filter_open;
        logic inactivity_timeout;
        logic alarm_timeout;
    } lfwf_stat_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HIGH = 4'b0010,
        ST_LOW  = 4'b0100,
        ST_PASS = 4'b1000
    } lfwf_state_t;

endpackage

// >>> verilog/lfwf_tick_timer.sv
// Purpose: timeout counter on oscillator ticks
// Assumes: tick is a one-cycle pulse on clk_sys
// Notes:   expired pulses one cycle after the LIMIT-th tick, then rewinds
`timescale 1ns/100ps
module lfwf_tick_timer #(
    parameter int LIMIT = 512
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic restart,
    input  wire logic tick,
    output logic      expired
);
    localparam int W = $clog2(LIMIT);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         exp_r;
    logic         exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (restart) begin
            cnt_nxt = '0;
        end else if (tick) begin
            if (cnt_r == W'(LIMIT - 1)) begin
                cnt_nxt = '0;
                exp_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;
endmodule

// >>> verilog/lfwf_top.sv
// Purpose: output-enable filter and timeouts of an lf wake-up receiver
// Assumes: demod_in is the asynchronous demodulator level
// Notes:   the 32 kHz oscillator is modelled as a tick divided off clk_sys
`timescale 1ns/100ps
`include "lfwf_consts.svh"

module lfwf_top #(
    parameter int OSC_DIV     = `LFWF_OSC_DIV,
    parameter int READY_TICKS = `LFWF_READY_TICKS
) (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire logic               demod_in,
    input  wire lfwf_pkg::lfwf_cfg_t config_word_zero,
    output logic                    demod_data_out,
    output lfwf_pkg::lfwf_stat_t    status
);
    import lfwf_pkg::*;

    localparam int DW = $clog2(OSC_DIV);
    localparam int RW = $clog2(READY_TICKS + 1);

    function automatic logic [8:0] low_need(input logic [1:0] sel);
        unique case (sel)
            `LFWF_SEL_2MS: low_need = `LFWF_TICKS_2MS;
            `LFWF_SEL_4MS: low_need = `LFWF_TICKS_4MS;
            default:       low_need = `LFWF_TICKS_1MS;
        endcase
    endfunction

    function automatic logic [8:0] high_need(input logic [1:0] sel);
        unique case (sel)
            `LFWF_SEL_2MS: high_need = `LFWF_TICKS_2MS;
            `LFWF_SEL_4MS: high_need = `LFWF_TICKS_4MS;
            default:       high_need = `LFWF_TICKS_1MS;
        endcase
    endfunction

    function automatic logic [8:0] total_max(input logic [1:0] h,
                                             input logic [1:0] l);
        logic [8:0] m;
        m = `LFWF_MAX_96;
        unique case ({h, l})
            4'h4, 4'h5: m = `LFWF_MAX_96;
            4'h6:       m = `LFWF_MAX_128;
            4'h7:       m = `LFWF_MAX_192;
            4'h8, 4'h9: m = `LFWF_MAX_128;
            4'ha:       m = `LFWF_MAX_160;
            4'hb:       m = `LFWF_MAX_250;
            4'hc, 4'hd: m = `LFWF_MAX_192;
            4'he:       m = `LFWF_MAX_256;
            4'hf:       m = `LFWF_MAX_320;
            default:    m = `LFWF_MAX_96;
        endcase
        return m;
    endfunction

    // two-flop synchroniser; din_s1_r feeds din_s2_r only
    logic din_s1_r;
    logic din_s2_r;
    logic din_d_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            din_d_r  <= 1'b0;
        end else begin
            din_s1_r <= demod_in;
            din_s2_r <= din_s1_r;
            din_d_r  <= din_s2_r;
        end
    end

    logic rise;
    logic fall;
    assign rise = din_s2_r & ~din_d_r;
    assign fall = ~din_s2_r & din_d_r;

    // oscillator tick and ready delay
    logic [DW-1:0] div_r;
    logic [DW-1:0] div_nxt;
    logic          tick_r;
    logic          tick_nxt;
    logic [RW-1:0] rdy_cnt_r;
    logic [RW-1:0] rdy_cnt_nxt;
    logic          ready_r;
    logic          ready_nxt;

    always_comb begin
        div_nxt     = div_r + 1'b1;
        tick_nxt    = 1'b0;
        rdy_cnt_nxt = rdy_cnt_r;
        ready_nxt   = ready_r;
        if (div_r == DW'(OSC_DIV - 1)) begin
            div_nxt  = '0;
            tick_nxt = 1'b1;
        end
        if (tick_r && !ready_r) begin
            if (rdy_cnt_r == RW'(READY_TICKS - 1)) begin
                ready_nxt = 1'b1;
            end
            rdy_cnt_nxt = rdy_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_r     <= '0;
            tick_r    <= 1'b0;
            rdy_cnt_r <= '0;
            ready_r   <= 1'b0;
        end else begin
            div_r     <= div_nxt;
            tick_r    <= tick_nxt;
            rdy_cnt_r <= rdy_cnt_nxt;
            ready_r   <= ready_nxt;
        end
    end

    // qualification state
    lfwf_state_t state_r;
    lfwf_state_t state_nxt;
    logic [8:0]  high_cnt_r;
    logic [8:0]  high_cnt_nxt;
    logic [8:0]  low_cnt_r;
    logic [8:0]  low_cnt_nxt;
    logic [8:0]  tot_cnt_r;
    logic [8:0]  tot_cnt_nxt;
    logic        data_r;
    logic        data_nxt;
    logic        bypass;
    logic        inact_exp;
    logic        alarm_exp;
    logic        inact_restart;
    logic        alarm_restart;
    logic [8:0]  need_h;
    logic [8:0]  need_l;
    logic [8:0]  limit;

    assign bypass = (config_word_zero.min_high_select == `LFWF_SEL_OFF);
    assign need_h = high_need(config_word_zero.min_high_select);
    assign need_l = low_need(config_word_zero.min_low_select);
    assign limit  = total_max(config_word_zero.min_high_select,
                              config_word_zero.min_low_select);

    always_comb begin
        state_nxt    = state_r;
        high_cnt_nxt = high_cnt_r;
        low_cnt_nxt  = low_cnt_r;
        tot_cnt_nxt  = tot_cnt_r;
        // saturating total and high counts; 9 bits already cover every limit
        if (tick_r && tot_cnt_r != 9'h1ff) begin
            tot_cnt_nxt = tot_cnt_r + 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (rise) begin
                    state_nxt    = ST_HIGH;
                    high_cnt_nxt = '0;
                    tot_cnt_nxt  = '0;
                end
            end
            ST_HIGH: begin
                if (tick_r && high_cnt_r != 9'h1ff) begin
                    high_cnt_nxt = high_cnt_r + 1'b1;
                end
                if (tot_cnt_r > limit) begin
                    state_nxt = ST_IDLE;
                end else if (fall) begin
                    low_cnt_nxt = '0;
                    state_nxt   = (high_cnt_r >= need_h) ? ST_LOW
                                                         : ST_IDLE;
                end
            end
            ST_LOW: begin
                if (tick_r) begin
                    low_cnt_nxt = low_cnt_r + 1'b1;
                end
                if (rise) begin
                    // a short gap restarts qualification from this edge
                    state_nxt    = ST_HIGH;
                    high_cnt_nxt = '0;
                    tot_cnt_nxt  = '0;
                end else if (low_cnt_r >= need_l) begin
                    state_nxt = (tot_cnt_r <= limit) ? ST_PASS
                                                     : ST_IDLE;
                end
            end
            ST_PASS: begin
                if (inact_exp) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        if (bypass || !ready_r) begin
            state_nxt = ST_IDLE;
        end
        if (bypass) begin
            data_nxt = ready_r & din_s2_r;
        end else begin
            data_nxt = ready_r & (state_r == ST_PASS) & din_s2_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r    <= ST_IDLE;
            high_cnt_r <= '0;
            low_cnt_r  <= '0;
            tot_cnt_r  <= '0;
            data_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            high_cnt_r <= high_cnt_nxt;
            low_cnt_r  <= low_cnt_nxt;
            tot_cnt_r  <= tot_cnt_nxt;
            data_r     <= data_nxt;
        end
    end

    // inactivity: open filter with no input edge; alarm: busy input never
    // qualifying, so a noisy field cannot keep the receiver awake unnoticed
    assign inact_restart = (state_r != ST_PASS) | rise | fall;
    assign alarm_restart = (state_r == ST_PASS) | bypass | ~ready_r
                         | ((state_r == ST_IDLE) & ~din_s2_r);

    lfwf_tick_timer #(
        .LIMIT(`LFWF_INACT_TICKS)
    ) u_inact (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(inact_restart),
        .tick   (tick_r),
        .expired(inact_exp)
    );

    lfwf_tick_timer #(
        .LIMIT(`LFWF_ALARM_TICKS)
    ) u_alarm (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(alarm_restart),
        .tick   (tick_r),
        .expired(alarm_exp)
    );

    assign demod_data_out            = data_r;
    assign status.ready              = ready_r;
    assign status.filter_open        = (state_r == ST_PASS);
    assign status.inactivity_timeout = inact_exp;
    assign status.alarm_timeout      = alarm_exp;
endmodule
